// >>> design/tipr_param_bank.sv
// Purpose: Parameter store of a two-channel thermocouple and millivolt input.
// Assumes: The controller access port and readings run on clk.
// Notes: One access is answered by an acknowledge pulse in the next cycle.
`timescale 1ns/1ps
module tipr_param_bank (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Parameter access port.
   input wire tipr_pkg::tipr_acc_t acc_mode,
   input wire logic [15:0] acc_addr,
   input wire logic [7:0] acc_sel,
   input wire logic [7:0] slot_num,
   input wire logic acc_wr,
   input wire logic acc_rd,
   input wire logic [15:0] acc_wdata,
   input wire logic run_mode,
   output logic [15:0] acc_rdata_r,
   output logic acc_ack_r,
   output logic acc_err_r,
   // Module-wide settings.
   output logic diag_irq_en_r,
   output logic [1:0] open_wire_en_r,
   output logic [1:0] temp_unit_r,
   output logic [1:0] mains_sel_r,
   // Per-channel settings.
   output logic [1:0] ch_active_r,
   output logic [1:0] ch_cjc_int_r,
   output logic [1:0] ch_cjc_ext_r,
   output logic [1:0][3:0] ch_tc_type_r,
   output logic [1:0][11:0] conv_time_r,
   // Readings and results.
   input wire logic [1:0] sample_valid,
   input wire logic [1:0][19:0] sample_raw,
   output logic [1:0][15:0] ch_value_r,
   output logic [1:0] ch_valid_r,
   output logic [1:0] hi_evt_r,
   output logic [1:0] lo_evt_r
);
   import tipr_pkg::*;

   logic [7:0] pb_r [PARAM_BYTES];
   tipr_map_t map;
   logic req;
   logic wr_ok;
   logic [15:0] rd_word;

   // Reset value of each byte in the store.
   function automatic logic [7:0] reset_val(input int i);
      int c;
      c = (i - int'(IDX_CH0)) % CH_BYTES;
      if (i == int'(IDX_MAINS)) return RST_MAINS;
      if (i < int'(IDX_CH0)) return RST_ZERO;
      if (c == int'(OFS_RANGE)) return RST_RANGE;
      if (c == int'(OFS_OPT)) return RST_OPT;
      if (c == int'(OFS_HI)) return RST_HI[15:8];
      if (c == int'(OFS_HI) + 1) return RST_HI[7:0];
      if (c == int'(OFS_LO)) return RST_LO[15:8];
      return RST_LO[7:0];
   endfunction

   // Writable bits of each byte in the store.
   function automatic logic [7:0] write_mask(input logic [4:0] i);
      if (i == IDX_DIAG) return MASK_DIAG;
      if (i == IDX_WIRE || i == IDX_LIMIT) return MASK_PAIR;
      if (i == IDX_UNIT || i == IDX_MAINS) return MASK_PAIR;
      if (i == IDX_SPARE) return RST_ZERO;
      return MASK_FULL;
   endfunction

   // Translates a record number and byte position.
   function automatic tipr_map_t map_record(input logic [7:0] rec, input logic [7:0] pos);
      tipr_map_t m;
      m = '0;
      if (rec == REC_ENABLES && pos < REC_ENABLES_LEN) begin
         m.ok = 1'b1;
         m.idx = IDX_DIAG + pos[4:0];
      end else if (rec == REC_SYSTEM && pos < REC_SYSTEM_LEN) begin
         m.ok = 1'b1;
         m.idx = IDX_UNIT + pos[4:0];
      end else if (rec == REC_CH0 && pos < 8'(CH_BYTES)) begin
         m.ok = 1'b1;
         m.idx = IDX_CH0 + pos[4:0];
      end else if (rec == REC_CH1 && pos < 8'(CH_BYTES)) begin
         m.ok = 1'b1;
         m.idx = IDX_CH1 + pos[4:0];
      end
      return m;
   endfunction

   // Translates an object index into one byte of the store.
   function automatic tipr_map_t map_index(input logic [15:0] ix);
      tipr_map_t m;
      logic [15:0] d;
      m = '0;
      d = ix - OBJ_BASE;
      if (ix >= OBJ_BASE && ix <= OBJ_LAST) begin
         m.ok = 1'b1;
         m.idx = d[4:0];
      end
      return m;
   endfunction

   // Translates a subindex into one whole parameter of the store.
   function automatic tipr_map_t map_sub(input logic [15:0] ix, input logic [7:0] sx,
                                         input logic [7:0] slot);
      tipr_map_t m;
      logic [7:0] k;
      m = '0;
      if (ix == OBJ_BASE + {8'h00, slot} && sx >= SUB_FIRST && sx <= SUB_LAST) begin
         m.ok = 1'b1;
         if (sx < SUB_CH0) begin
            k = sx - SUB_FIRST;
            m.idx = k[4:0];
         end else begin
            k = (sx < SUB_CH1) ? sx - SUB_CH0 : sx - SUB_CH1;
            m.idx = (sx < SUB_CH1) ? IDX_CH0 : IDX_CH1;
            if (k < 8'h02) m.idx = m.idx + k[4:0];
            else m.idx = m.idx + OFS_HI + 5'((k - 8'h02) << 1);
            m.two = k >= 8'h02;
         end
      end
      return m;
   endfunction

   // Conversion time of an option code under the chosen mains rejection.
   function automatic logic [11:0] conv_time(input logic [7:0] opt, input logic [1:0] mains);
      if (mains == MAINS_60HZ) begin
         if (opt == OPT_SLOW) return CT60_SLOW;
         if (opt == OPT_MID) return CT60_MID;
         return CT60_FAST;
      end
      if (opt == OPT_SLOW) return CT50_SLOW;
      if (opt == OPT_MID) return CT50_MID;
      return CT50_FAST;
   endfunction

   // Address translation for the current access.
   always_comb begin
      map = '0;
      if (acc_mode == TIPR_ACC_RECORD) map = map_record(acc_addr[7:0], acc_sel);
      else if (acc_mode == TIPR_ACC_INDEX) map = map_index(acc_addr);
      else if (acc_mode == TIPR_ACC_SUB) map = map_sub(acc_addr, acc_sel, slot_num);
   end

   assign req = acc_wr || acc_rd;
   // Writes during run are refused so settings change only at stop.
   assign wr_ok = acc_wr && map.ok && !run_mode;
   assign rd_word = map.two ? {pb_r[map.idx], pb_r[map.idx + 5'h01]} : {8'h00, pb_r[map.idx]};

   // Parameter store, with reserved bits forced to zero on every write.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         for (int i = 0; i < PARAM_BYTES; i++) pb_r[i] <= reset_val(i);
      end else if (wr_ok) begin
         if (map.two) begin
            pb_r[map.idx] <= acc_wdata[15:8];
            pb_r[map.idx + 5'h01] <= acc_wdata[7:0];
         end else begin
            pb_r[map.idx] <= acc_wdata[7:0] & write_mask(map.idx);
         end
      end
   end

   // Answer to each access, one cycle after the request.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         acc_ack_r <= 1'b0;
         acc_err_r <= 1'b0;
         acc_rdata_r <= '0;
      end else begin
         acc_ack_r <= req;
         acc_err_r <= req && (!map.ok || (acc_wr && run_mode));
         if (acc_rd && !acc_wr && map.ok) acc_rdata_r <= rd_word;
      end
   end

   // Module-wide settings decoded from the store.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         diag_irq_en_r <= 1'b0;
         open_wire_en_r <= '0;
         temp_unit_r <= '0;
         mains_sel_r <= RST_MAINS[1:0];
      end else begin
         diag_irq_en_r <= pb_r[IDX_DIAG] == MASK_DIAG;
         open_wire_en_r <= pb_r[IDX_WIRE][1:0];
         temp_unit_r <= pb_r[IDX_UNIT][1:0];
         mains_sel_r <= pb_r[IDX_MAINS][1:0];
      end
   end

   tipr_chan_if cif[NUM_CH] ();

   // Per-channel decode and checker.
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      localparam logic [4:0] BASE = (c == 0) ? IDX_CH0 : IDX_CH1;
      logic [7:0] code;
      assign code = pb_r[BASE + OFS_RANGE];
      assign cif[c].range_code = code;
      assign cif[c].limit_en = pb_r[IDX_LIMIT][c];
      assign cif[c].hi_lim = {pb_r[BASE + OFS_HI], pb_r[BASE + OFS_HI + 5'h01]};
      assign cif[c].lo_lim = {pb_r[BASE + OFS_LO], pb_r[BASE + OFS_LO + 5'h01]};

      // Sensor type, compensation and conversion time of this channel.
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            ch_active_r[c] <= 1'b1;
            ch_cjc_int_r[c] <= 1'b1;
            ch_cjc_ext_r[c] <= 1'b0;
            ch_tc_type_r[c] <= RST_RANGE[3:0];
            conv_time_r[c] <= CT50_FAST;
         end else begin
            ch_active_r[c] <= code != RANGE_OFF;
            ch_cjc_int_r[c] <= code[7:4] == CJC_INT && code[3:0] <= TC_TYPE_MAX;
            ch_cjc_ext_r[c] <= code[7:4] == CJC_EXT && code[3:0] <= TC_TYPE_MAX;
            ch_tc_type_r[c] <= code[3:0];
            conv_time_r[c] <= conv_time(pb_r[BASE + OFS_OPT], pb_r[IDX_MAINS][1:0]);
         end
      end

      tipr_limit_chk u_chk (
         .clk(clk),
         .resetn(resetn),
         .cfg(cif[c]),
         .sample_valid(sample_valid[c]),
         .sample_raw(sample_raw[c]),
         .value_r(ch_value_r[c]),
         .valid_r(ch_valid_r[c]),
         .hi_evt_r(hi_evt_r[c]),
         .lo_evt_r(lo_evt_r[c])
      );
   end

   rst_vals_a: assert property (@(posedge clk) disable iff (!resetn)
      $rose(resetn) |-> pb_r[IDX_MAINS] == RST_MAINS && pb_r[IDX_CH0] == RST_RANGE
      && pb_r[IDX_CH1 + OFS_OPT] == RST_OPT && pb_r[IDX_CH0 + OFS_HI] == RST_HI[15:8])
      else $error("Parameter store left reset with wrong values");
   diag_code_a: assert property (@(posedge clk) disable iff (!resetn)
      (pb_r[IDX_DIAG] == RST_ZERO || pb_r[IDX_DIAG] == MASK_DIAG)
      ##1 diag_irq_en_r == $past(pb_r[IDX_DIAG][6]))
      else $error("Diagnostic enable byte or output wrong");
   rsvd_bits_a: assert property (@(posedge clk) disable iff (!resetn)
      pb_r[IDX_WIRE][7:2] == '0 && pb_r[IDX_LIMIT][7:2] == '0 && pb_r[IDX_SPARE] == '0
      && pb_r[IDX_UNIT][7:2] == '0 && pb_r[IDX_MAINS][7:2] == '0)
      else $error("Reserved parameter bits are set");
   run_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
      acc_wr && run_mode |=> acc_ack_r && acc_err_r)
      else $error("Write during run was not refused");
   ack_next_a: assert property (@(posedge clk) disable iff (!resetn)
      acc_rd && !acc_wr && acc_mode == TIPR_ACC_RECORD && acc_addr[7:0] == REC_SYSTEM
      && acc_sel == 8'h01 |=> acc_ack_r && !acc_err_r
      && acc_rdata_r == {8'h00, $past(pb_r[IDX_MAINS])})
      else $error("Record read of mains byte answered wrongly");
   idx_range_a: assert property (@(posedge clk) disable iff (!resetn)
      req && acc_mode == TIPR_ACC_INDEX && acc_addr > OBJ_LAST |=> acc_err_r)
      else $error("Index beyond last parameter accepted");
   chan_off_a: assert property (@(posedge clk) disable iff (!resetn)
      pb_r[IDX_CH1] == RANGE_OFF [*2] |-> !ch_active_r[1] && !ch_valid_r[1])
      else $error("Deactivated channel still active");
   conv_fast_a: assert property (@(posedge clk) disable iff (!resetn)
      pb_r[IDX_CH0 + OFS_OPT] == RST_OPT && pb_r[IDX_MAINS] == RST_MAINS
      |=> conv_time_r[0] == CT50_FAST)
      else $error("Conversion time wrong for option 02h at 50 Hz");
   rec_wr_c: cover property (@(posedge clk) disable iff (!resetn)
      acc_wr && map.ok && acc_mode == TIPR_ACC_RECORD ##1 acc_ack_r && !acc_err_r);
   sub_wr_c: cover property (@(posedge clk) disable iff (!resetn)
      wr_ok && acc_mode == TIPR_ACC_SUB && map.two);
   lo_evt_c: cover property (@(posedge clk) disable iff (!resetn) lo_evt_r[0]);
endmodule

// >>> include/tipr_pkg.sv
// Purpose: Shared constants and types of the thermocouple input parameter bank.
// Assumes: Parameter bytes are held in object index order, 18 bytes from index 3100h.
// Notes: Limit words are stored high byte first at the lower byte position.
// Function
// - Diagnostic interrupt enable byte: 00h off, 40h on, resets to 00h.
// - Open-wire byte: bit 0 channel 0, bit 1 channel 1; rest reserved.
// - Limit-check byte: bit 0 channel 0, bit 1 channel 1; rest reserved.
// - Unit byte bits 1:0 pick Celsius, Fahrenheit or Kelvin; resets to 00h.
// - Mains byte bits 1:0: 01 rejects 60 Hz, 10 rejects 50 Hz.
// - Mains byte resets to 02h and lives in record 01h with unit byte.
// - Per-channel range code resets to C1h; FFh switches the channel off.
// - Per-channel option code resets to 02h and follows the range code.
// - Per-channel signed upper limit word resets to 7FFFh and is compared.
// - Per-channel signed lower limit word resets to 8000h, after upper limit.
// - Records 00h enables, 01h unit and mains, 80h and 81h channels.
// - Object indices from 3100h map bytes; limit words take two; last 3111h.
// - Subindices 01h to 0Eh under index 3100h plus slot, in record order.
// - Code 11h scales 80 mV to 27648, clamped to 32511 and -32512.
// - Code 21h scales 80 mV to 16384, clamped to plus or minus 20480.
// - Range code low nibble is sensor type, high nibble B external, C internal.
// - Option code sets conversion time per channel, depending on mains choice.
package tipr_pkg;
   localparam int NUM_CH = 2;
   localparam int PARAM_BYTES = 18;
   localparam int CH_BYTES = 6;

   // Byte positions in the flat parameter store.
   localparam logic [4:0] IDX_DIAG = 5'h00;
   localparam logic [4:0] IDX_WIRE = 5'h01;
   localparam logic [4:0] IDX_LIMIT = 5'h02;
   localparam logic [4:0] IDX_SPARE = 5'h03;
   localparam logic [4:0] IDX_UNIT = 5'h04;
   localparam logic [4:0] IDX_MAINS = 5'h05;
   localparam logic [4:0] IDX_CH0 = 5'h06;
   localparam logic [4:0] IDX_CH1 = 5'h0C;
   localparam logic [4:0] OFS_RANGE = 5'h00;
   localparam logic [4:0] OFS_OPT = 5'h01;
   localparam logic [4:0] OFS_HI = 5'h02;
   localparam logic [4:0] OFS_LO = 5'h04;

   // Record numbers and their byte counts.
   localparam logic [7:0] REC_ENABLES = 8'h00;
   localparam logic [7:0] REC_SYSTEM = 8'h01;
   localparam logic [7:0] REC_CH0 = 8'h80;
   localparam logic [7:0] REC_CH1 = 8'h81;
   localparam logic [7:0] REC_ENABLES_LEN = 8'h04;
   localparam logic [7:0] REC_SYSTEM_LEN = 8'h02;

   // Object index and subindex bounds.
   localparam logic [15:0] OBJ_BASE = 16'h3100;
   localparam logic [15:0] OBJ_LAST = 16'h3111;
   localparam logic [7:0] SUB_FIRST = 8'h01;
   localparam logic [7:0] SUB_LAST = 8'h0E;
   localparam logic [7:0] SUB_CH0 = 8'h07;
   localparam logic [7:0] SUB_CH1 = 8'h0B;

   // Reset values.
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_MAINS = 8'h02;
   localparam logic [7:0] RST_RANGE = 8'hC1;
   localparam logic [7:0] RST_OPT = 8'h02;
   localparam logic [15:0] RST_HI = 16'h7FFF;
   localparam logic [15:0] RST_LO = 16'h8000;

   // Writable bit masks; all other bits are reserved.
   localparam logic [7:0] MASK_DIAG = 8'h40;
   localparam logic [7:0] MASK_PAIR = 8'h03;
   localparam logic [7:0] MASK_FULL = 8'hFF;

   // Codes.
   localparam logic [7:0] RANGE_OFF = 8'hFF;
   localparam logic [7:0] RANGE_MV_FULL = 8'h11;
   localparam logic [7:0] RANGE_MV_HALF = 8'h21;
   localparam logic [3:0] CJC_EXT = 4'hB;
   localparam logic [3:0] CJC_INT = 4'hC;
   localparam logic [3:0] TC_TYPE_MAX = 4'h9;
   localparam logic [1:0] MAINS_60HZ = 2'h1;
   localparam logic [7:0] OPT_SLOW = 8'h00;
   localparam logic [7:0] OPT_MID = 8'h01;

   // Millivolt scaling: raw input counts 65536 per 80 mV.
   localparam int RAW_W = 20;
   localparam int MV_SHIFT = 16;
   localparam logic signed [35:0] FULL_GAIN = 36'sh0_0000_6C00;
   localparam logic signed [19:0] FULL_OVER = 20'sh0_7EFF;
   localparam logic signed [19:0] FULL_UNDER = 20'shF_8100;
   localparam logic signed [19:0] HALF_OVER = 20'sh0_5000;
   localparam logic signed [19:0] HALF_UNDER = 20'shF_B000;
   localparam int HALF_SHIFT = 2;

   // Conversion times in units of 0.1 ms.
   localparam logic [11:0] CT50_SLOW = 12'hCA9;
   localparam logic [11:0] CT50_MID = 12'h66A;
   localparam logic [11:0] CT50_FAST = 12'h34A;
   localparam logic [11:0] CT60_SLOW = 12'hA91;
   localparam logic [11:0] CT60_MID = 12'h55C;
   localparam logic [11:0] CT60_FAST = 12'h2C1;

   // Parameter access modes.
   typedef enum logic [1:0] {
      TIPR_ACC_RECORD,
      TIPR_ACC_INDEX,
      TIPR_ACC_SUB
   } tipr_acc_t;

   // Result of translating an access address into store positions.
   typedef struct packed {
      logic ok;
      logic two;
      logic [4:0] idx;
   } tipr_map_t;
endpackage

// >>> include/tipr_chan_if.sv
// Purpose: Carries one channel's parameters from the bank to its checker.
// Assumes: All signals run on the bank clock.
// Notes: The bank drives every field straight from its parameter store.
`timescale 1ns/1ps
interface tipr_chan_if;
   logic [7:0] range_code;
   logic limit_en;
   logic [15:0] hi_lim;
   logic [15:0] lo_lim;
   modport bank (output range_code, output limit_en, output hi_lim, output lo_lim);
   modport chk (input range_code, input limit_en, input hi_lim, input lo_lim);
endinterface

// >>> design/tipr_limit_chk.sv
// Purpose: Scales one channel's reading and watches it against its limits.
// Assumes: Raw readings arrive on the bank clock, 65536 counts per 80 mV.
// Notes: Thermocouple codes pass the upstream value through unchanged.
`timescale 1ns/1ps
module tipr_limit_chk (
   // Clock and reset.
   input wire logic clk,
   input wire logic resetn,
   // Channel parameters.
   tipr_chan_if.chk cfg,
   // Reading in.
   input wire logic sample_valid,
   input wire logic signed [19:0] sample_raw,
   // Result and events.
   output logic signed [15:0] value_r,
   output logic valid_r,
   output logic hi_evt_r,
   output logic lo_evt_r
);
   import tipr_pkg::*;

   logic signed [15:0] value_nxt;
   logic take;
   logic above_r;
   logic below_r;

   // Converts a raw reading according to the range code.
   function automatic logic signed [15:0] scale_val(input logic [7:0] code,
                                                    input logic signed [19:0] raw);
      logic signed [35:0] p;
      logic signed [19:0] q;
      p = 36'(raw) * FULL_GAIN;
      q = raw;
      if (code == RANGE_MV_FULL) begin
         q = p[MV_SHIFT+19:MV_SHIFT];
         if (q > FULL_OVER) q = FULL_OVER;
         if (q < FULL_UNDER) q = FULL_UNDER;
      end else if (code == RANGE_MV_HALF) begin
         q = raw >>> HALF_SHIFT;
         if (q > HALF_OVER) q = HALF_OVER;
         if (q < HALF_UNDER) q = HALF_UNDER;
      end
      return q[15:0];
   endfunction

   // A deactivated channel ignores its readings.
   assign take = sample_valid && (cfg.range_code != RANGE_OFF);
   assign value_nxt = scale_val(cfg.range_code, sample_raw);

   // Registers the scaled value.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         value_r <= '0;
         valid_r <= 1'b0;
      end else begin
         valid_r <= take;
         if (take) value_r <= value_nxt;
      end
   end

   // Raises one event on entry into each out-of-limit zone.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         above_r <= 1'b0;
         below_r <= 1'b0;
         hi_evt_r <= 1'b0;
         lo_evt_r <= 1'b0;
      end else if (!cfg.limit_en) begin
         above_r <= 1'b0;
         below_r <= 1'b0;
         hi_evt_r <= 1'b0;
         lo_evt_r <= 1'b0;
      end else begin
         hi_evt_r <= take && (value_nxt > $signed(cfg.hi_lim)) && !above_r;
         lo_evt_r <= take && (value_nxt < $signed(cfg.lo_lim)) && !below_r;
         if (take) begin
            above_r <= value_nxt > $signed(cfg.hi_lim);
            below_r <= value_nxt < $signed(cfg.lo_lim);
         end
      end
   end

   full_clamp_a: assert property (@(posedge clk) disable iff (!resetn)
      valid_r && cfg.range_code == RANGE_MV_FULL && $stable(cfg.range_code)
      |-> value_r <= 16'sh7EFF && value_r >= 16'sh8100)
      else $error("Full-scale millivolt value out of clamp range");
   half_clamp_a: assert property (@(posedge clk) disable iff (!resetn)
      valid_r && cfg.range_code == RANGE_MV_HALF && $stable(cfg.range_code)
      |-> value_r <= 16'sh5000 && value_r >= 16'shB000)
      else $error("Half-scale millivolt value out of clamp range");
   hi_event_a: assert property (@(posedge clk) disable iff (!resetn)
      hi_evt_r |-> valid_r && $past(cfg.limit_en) && value_r > $signed($past(cfg.hi_lim)))
      else $error("High event without enabled limit crossing");
   hi_event_c: cover property (@(posedge clk) disable iff (!resetn) hi_evt_r);
endmodule

// >>> tb/tipr_ctrl_model.sv
// Purpose: Controller model that drives the parameter access port of the bank.
// Assumes: Requests start on a falling edge, one at a time.
// Notes: Run stays low unless a scenario raises it to see a write refused.
`timescale 1ns/1ps
module tipr_ctrl_model (
   // Clock.
   input wire logic clk,
   // Requests toward the bank.
   output tipr_pkg::tipr_acc_t acc_mode,
   output logic [15:0] acc_addr,
   output logic [7:0] acc_sel,
   output logic [7:0] slot_num,
   output logic acc_wr,
   output logic acc_rd,
   output logic [15:0] acc_wdata,
   output logic run_mode,
   // Answers from the bank.
   input wire logic [15:0] acc_rdata_r,
   input wire logic acc_ack_r,
   input wire logic acc_err_r
);
   import tipr_pkg::*;
   // The port idles, and parameters move only while the system is stopped.
   initial begin
      acc_mode = TIPR_ACC_RECORD;
      {acc_addr, acc_sel, acc_wr, acc_rd, acc_wdata} = '0;
      slot_num = 8'h05;
      run_mode = 1'b0;
   end
   // One request pulse; the answer is taken at the next falling edge and returned as ack, err, data.
   task automatic xfer(input tipr_acc_t m, input logic [15:0] a, input logic [7:0] s,
         input logic [15:0] d, input logic w, output logic [17:0] q);
      @(negedge clk);
      acc_mode = m;
      acc_addr = a;
      acc_sel = s;
      acc_wdata = d;
      acc_wr = w;
      acc_rd = !w;
      @(negedge clk);
      acc_wr = 1'b0;
      acc_rd = 1'b0;
      q = {acc_ack_r, acc_err_r, acc_rdata_r};
   endtask
endmodule

// >>> tb/thermo_input_param_record_tb.sv
// Purpose: Self-checking bench comparing the bank with a byte-level store model.
// Assumes: Inputs change on the falling edge.
// Notes: Channel 1 is switched off, so readings run on channel 0 only.
`timescale 1ns/1ps
module thermo_input_param_record_tb;
   import tipr_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [1:0] sample_valid = 2'b00;
   logic [1:0][19:0] sample_raw = '0;
   tipr_acc_t acc_mode;
   logic [15:0] acc_addr, acc_wdata, acc_rdata_r;
   logic [7:0] acc_sel, slot_num;
   logic acc_wr, acc_rd, run_mode, acc_ack_r, acc_err_r, diag_irq_en_r, hs, ls;
   logic [1:0] open_wire_en_r, temp_unit_r, mains_sel_r, ch_active_r, ch_cjc_int_r;
   logic [1:0] ch_cjc_ext_r, ch_valid_r, hi_evt_r, lo_evt_r;
   logic [1:0][3:0] ch_tc_type_r;
   logic [1:0][11:0] conv_time_r;
   logic [1:0][15:0] ch_value_r;
   logic [0:17][7:0] st = 144'h0000_0000_0002_C102_7FFF_8000_C102_7FFF_8000;
   logic [0:8][15:0] dw = 144'h0040_0041_0401_0402_0501_0700_0701_0702_0502;
   logic [0:4][19:0] dr = 100'h1000_07FF_FF80_0000_0000_F000_0;
   logic [17:0] q;
   logic [15:0] lf = 16'h0013;
   int mismatches = 0;
   int cmp_count = 0;
   int ct [6] = '{3241, 1642, 842, 2705, 1372, 705};
   int si [14] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 12, 13, 14, 16};
   // Free-running clock.
   always #25 clk = ~clk;
   // Bank and controller.
   tipr_param_bank u_dut (.clk, .resetn, .acc_mode, .acc_addr, .acc_sel, .slot_num, .acc_wr,
      .acc_rd, .acc_wdata, .run_mode, .acc_rdata_r, .acc_ack_r, .acc_err_r, .diag_irq_en_r,
      .open_wire_en_r, .temp_unit_r, .mains_sel_r, .ch_active_r, .ch_cjc_int_r, .ch_cjc_ext_r,
      .ch_tc_type_r, .conv_time_r, .sample_valid, .sample_raw, .ch_value_r, .ch_valid_r,
      .hi_evt_r, .lo_evt_r);
   tipr_ctrl_model u_ctrl (.clk, .acc_mode, .acc_addr, .acc_sel, .slot_num, .acc_wr, .acc_rd,
      .acc_wdata, .run_mode, .acc_rdata_r, .acc_ack_r, .acc_err_r);
   // Random source.
   function automatic logic [15:0] nx(input logic [15:0] x);
      return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
   endfunction
   // Writable bits of each stored byte.
   function automatic logic [7:0] msk(input int i);
      return i == 0 ? 8'h40 : i == 3 ? 8'h00 : i < 6 ? 8'h03 : 8'hFF;
   endfunction
   // Expected result of a reading under a range code.
   function automatic int scl(input logic [7:0] c, input logic signed [19:0] r);
      int v;
      v = int'(signed'(r[15:0]));
      if (c == 8'h11) v = int'((longint'(r) * 27648) >>> 16);
      if (c == 8'h21) v = r >>> 2;
      if (c == 8'h11) v = v > 32511 ? 32511 : v < -32512 ? -32512 : v;
      if (c == 8'h21) v = v > 20480 ? 20480 : v < -20480 ? -20480 : v;
      return v;
   endfunction
   // Compare and count.
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         mismatches++;
         $display("FAIL %s expected %h seen %h", n, e, s);
      end
   endtask
   // Final report.
   task automatic conclude;
      $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Decoded settings against the store model.
   task automatic dec;
      logic [7:0] r;
      int k;
      chk("diag", diag_irq_en_r, st[0] == 8'h40);
      chk("modes", {open_wire_en_r, temp_unit_r, mains_sel_r},
         {st[1][1:0], st[4][1:0], st[5][1:0]});
      for (int c = 0; c < 2; c++) begin
         r = st[6 + 6 * c];
         k = (st[5][1:0] == 2'b01 ? 3 : 0) + (st[7 + 6 * c] > 8'h01 ? 2 : int'(st[7 + 6 * c]));
         chk("active", ch_active_r[c], r != 8'hFF);
         chk("range", {ch_cjc_int_r[c], ch_cjc_ext_r[c], ch_tc_type_r[c]},
            {r[7:4] == 4'hC && r[3:0] < 4'hA, r[7:4] == 4'hB && r[3:0] < 4'hA, r[3:0]});
         chk("conv time", conv_time_r[c], ct[k]);
      end
   endtask
   // Byte write by object index, then settings check.
   task automatic wr(input int i, input logic [7:0] d);
      u_ctrl.xfer(TIPR_ACC_INDEX, OBJ_BASE + 16'(i), 8'h00, {8'h00, d}, 1'b1, q);
      chk("write ack", q[17:16], 2'b10);
      st[i] = d & msk(i);
      @(negedge clk);
      dec();
   endtask
   // Read and compare ack, error and data.
   task automatic acc(input tipr_acc_t m, input logic [15:0] a, input int s, input logic [17:0] e);
      u_ctrl.xfer(m, a, 8'(s), 16'h0000, 1'b0, q);
      chk("read", q, e);
   endtask
   // One reading on both channels; channel 1 is off.
   task automatic smp(input logic [19:0] r);
      int v;
      logic ab, bl;
      v = scl(st[6], r);
      ab = st[2][0] && v > int'(signed'({st[8], st[9]}));
      bl = st[2][0] && v < int'(signed'({st[10], st[11]}));
      sample_raw = {r, r};
      sample_valid = 2'b11;
      @(negedge clk);
      sample_valid = 2'b00;
      chk("valid", ch_valid_r, 2'b01);
      chk("value", ch_value_r[0], v[15:0]);
      chk("events", {hi_evt_r[0], lo_evt_r[0]}, {ab && !hs, bl && !ls});
      hs = ab;
      ls = bl;
   endtask
   // Hang guard.
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      conclude();
   end
   // Main sequence.
   initial begin
      int k;
      {hs, ls} = 2'b00;
      repeat (2) @(negedge clk);
      resetn = 1'b1;
      dec();
      for (int i = 0; i < 18; i++)
         acc(TIPR_ACC_INDEX, OBJ_BASE + 16'(i), 0, {10'h200, st[i]});
      for (int i = 0; i < 9; i++) wr(int'(dw[i][12:8]), dw[i][7:0]);
      for (int i = 0; i < 18; i++) begin
         lf = nx(lf);
         wr(i, lf[7:0]);
      end
      for (int i = 0; i < 18; i++) begin
         k = i < 4 ? i : i < 6 ? i - 4 : (i - 6) % 6;
         acc(TIPR_ACC_RECORD, i < 4 ? 16'h0 : i < 6 ? 16'h1 : 16'(8'h80 + (i - 6) / 6), k,
            {10'h200, st[i]});
      end
      u_ctrl.run_mode = 1'b1;
      u_ctrl.xfer(TIPR_ACC_INDEX, OBJ_BASE, 8'h00, 16'h00FF, 1'b1, q);
      chk("run write", q[17:16], 2'b11);
      u_ctrl.run_mode = 1'b0;
      for (int i = 0; i < 3; i++) begin
         u_ctrl.xfer(tipr_acc_t'(i), i == 1 ? 16'h3112 : 16'h3105, 8'h0F, 16'h0, 1'b0, q);
         chk("unmapped", q[17:16], 2'b11);
      end
      u_ctrl.xfer(TIPR_ACC_SUB, 16'h3105, 8'h09, 16'h03E8, 1'b1, q);
      u_ctrl.xfer(TIPR_ACC_SUB, 16'h3105, 8'h0A, 16'hFC18, 1'b1, q);
      st[8:11] = 32'h03E8_FC18;
      for (int s = 1; s < 15; s++) begin
         k = si[s - 1];
         acc(TIPR_ACC_SUB, 16'h3105, s, s inside {9, 10, 13, 14} ?
            {2'b10, st[k], st[k + 1]} : {10'h200, st[k]});
      end
      wr(2, 8'h01);
      wr(12, 8'hFF);
      for (int c = 0; c < 3; c++) begin
         wr(6, c == 0 ? 8'h11 : c == 1 ? 8'h21 : 8'hC1);
         for (int j = 0; j < 11; j++) begin
            lf = nx(lf);
            smp(j < 5 ? dr[j] : {lf[3:0], lf});
         end
      end
      wr(2, 8'h00);
      smp(20'h1_0000);
      conclude();
   end
endmodule
